// file: core/fcad_core.sv
// Command front end: fallback mode, channel address decode, setup and reply.
`default_nettype none
module fcad_core
  import fcad_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        force_pin_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0][19:0] chan_value,
  input  wire logic [3:0]  chan_neg,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [19:0] bit_cycles,
  output logic             fallback,
  output logic             modbus_active,
  output logic      [3:0]  chan_enable,
  output logic             prog_reset
);
  typedef struct packed {
    logic [31:0]  dat;
    logic         ack;
    fcad_state_t  st;
    fcad_cmd_t    cmd;
    logic [7:0]   cmd_addr;
    logic [13:0]  cmd_arg;
    logic [7:0]   addr;
    logic [2:0]   baud_sel;
    logic         parity_en;
    logic         linefeed;
    logic         alarm_en;
    logic [1:0]   reply_delay;
    logic         modbus_req;
    logic         modbus_act;
    logic [1:0]   chan;
    logic         addr_err;
    logic [3:0]   idx;
    logic [7:0]   reply;
    logic         reply_valid;
    logic [19:0]  bitc;
    logic         prst;
    logic         fb;
    logic [3:0]   chen;
  } fcad_core_t;

  fcad_core_t q;
  fcad_core_t next_q;
  logic       pin_level;
  logic       pin_rise;
  logic       buf_ready;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] offs;
  logic       legal;
  logic [19:0] val;
  logic [3:0]  dig;
  logic [19:0] scale;
  logic [19:0] rem;
  wire  logic [3:0] chan_hit;
  wire  logic [5:0] illegal_hit;

  // Characters that fallback mode refuses as an address; an assigned channel address still decodes.
  localparam logic [5:0][7:0] ILLEGAL_CHARS = {CH_NUL, CH_CR, CH_DOLLAR, CH_HASH,
                                              CH_LBRACE, CH_RBRACE};

  // One comparator per channel: channel i answers to the first address plus i.
  // The sum wraps in eight bits, so a first address near the top still decodes.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      assign chan_hit[gi] = (q.cmd_addr == (q.addr + 8'(gi)));
    end
    for (gi = 0; gi < 6; gi++) begin : g_illegal
      assign illegal_hit[gi] = (q.cmd_addr == ILLEGAL_CHARS[gi]);
    end
  endgenerate

  fcad_pin_filter #(.STABLE_CYCLES(DEBOUNCE)) u_pin (
    .clock   (clock),
    .rst_b   (rst_b),
    .pin_raw (force_pin_b),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  fcad_skid #(.WIDTH(8)) u_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (q.reply_valid),
    .in_ready  (buf_ready),
    .in_data   (q.reply),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_byte)
  );

  // Bit period per stored baud code: the 300-baud period divided by two to the code.
  function automatic logic [19:0] fcad_bits(input logic [2:0] sel);
    fcad_bits = 20'(FALLBACK_BIT_CYCLES >> sel);
  endfunction : fcad_bits

  always_comb begin
    next_q             = q;
    next_q.ack         = 1'b0;
    next_q.prst        = 1'b0;
    next_q.reply_valid = q.reply_valid && !buf_ready;
    wr_hit = wb_cyc_i && wb_stb_i && !q.ack && wb_we_i;
    rd_hit = wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i;
    offs   = q.cmd_addr - q.addr;
    legal  = !(|illegal_hit);
    val    = chan_value[q.chan];
    dig    = 4'h0;
    scale  = 20'd1;
    rem    = 20'h0;

    next_q.fb   = !pin_level;
    next_q.chen = (!pin_level) ? 4'hf : 4'hf;
    if (pin_rise) begin
      next_q.prst       = 1'b1;
      next_q.modbus_act = q.modbus_req;
      next_q.st         = FCAD_ST_IDLE;
    end
    next_q.bitc = (!pin_level) ? FALLBACK_BIT_CYCLES : fcad_bits(q.baud_sel);

    if (wr_hit || rd_hit) begin
      next_q.ack = 1'b1;
      next_q.dat = 32'h0;
    end
    if (wr_hit && wb_adr_i == OFS_CMD && wb_sel_i[0] && q.st == FCAD_ST_IDLE) begin
      next_q.cmd      = fcad_cmd_t'(wb_dat_i[2:0]);
      next_q.cmd_addr = wb_dat_i[15:8];
      next_q.cmd_arg  = wb_dat_i[29:16];
      next_q.st       = FCAD_ST_EXEC;
    end else if (rd_hit && wb_adr_i == OFS_SETUP) begin
      next_q.dat = {14'h0, q.modbus_req, q.reply_delay, q.alarm_en, q.linefeed,
                    q.parity_en, q.baud_sel, 1'b0, q.addr};
    end else if (rd_hit && wb_adr_i == OFS_STATUS) begin
      next_q.dat = {23'h0, q.addr_err, q.chan, q.fb, q.modbus_act, 1'b0, q.st};
    end else if (rd_hit && wb_adr_i == OFS_DATA) begin
      next_q.dat = {12'h0, val};
    end

    case (q.st)
      FCAD_ST_IDLE: begin
      end
      FCAD_ST_EXEC: begin
        next_q.st       = FCAD_ST_IDLE;
        next_q.addr_err = 1'b0;
        // Fallback answers any legal character; otherwise only assigned ones.
        if (|chan_hit) begin
          next_q.chan = offs[1:0];
        end else if (q.fb && legal) begin
          next_q.chan = 2'h0;
        end else begin
          next_q.addr_err = 1'b1;
        end
        if ((|chan_hit) || (q.fb && legal)) begin
          case (q.cmd)
            FCAD_CMD_READ_DATA: begin
              next_q.st  = FCAD_ST_REPLY;
              next_q.idx = 4'h0;
            end
            FCAD_CMD_SETUP_WR: begin
              // Stored setup values change only here or, for modbus_req, by the Modbus commands; never on entering fallback.
              next_q.addr        = q.cmd_arg[7:0] | 8'h00;
              next_q.baud_sel    = q.cmd_arg[10:8];
              next_q.parity_en   = q.cmd_arg[11];
              next_q.linefeed    = q.cmd_arg[12];
              next_q.alarm_en    = q.cmd_arg[13];
            end
            FCAD_CMD_MB_EN:  next_q.modbus_req = 1'b1;
            FCAD_CMD_MB_DIS: begin
              next_q.modbus_req = 1'b0;
              next_q.modbus_act = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      FCAD_ST_REPLY: begin
        if (!q.reply_valid || buf_ready) begin
          // Digits are produced most significant first by division and remainder.
          case (q.idx)
            4'h0: next_q.reply = CH_STAR;
            4'h1: next_q.reply = chan_neg[q.chan] ? CH_MINUS : CH_PLUS;
            4'h7: next_q.reply = CH_DOT;
            default: begin
              case (q.idx)
                4'h2: scale = 20'd10000;
                4'h3: scale = 20'd1000;
                4'h4: scale = 20'd100;
                4'h5: scale = 20'd10;
                4'h6: scale = 20'd1;
                4'h8: scale = 20'd10;
                default: scale = 20'd1;
              endcase
              if (q.idx >= 4'h8) begin
                rem = val % 20'd100;
              end else begin
                rem = (val / 20'd100) % 20'd100000;
              end
              dig = 4'((rem / scale) % 20'd10);
              next_q.reply = CH_ZERO + {4'h0, dig};
            end
          endcase
          next_q.reply_valid = 1'b1;
          if (q.idx == 4'(REPLY_LEN - 1)) begin
            next_q.st = FCAD_ST_IDLE;
          end else begin
            next_q.idx = q.idx + 4'h1;
          end
        end
      end
      default: next_q.st = FCAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q             <= '0;
      q.st          <= FCAD_ST_IDLE;
      q.cmd         <= FCAD_CMD_NONE;
      q.addr        <= RST_ADDR;
      q.baud_sel    <= RST_BAUD_SEL;
      q.parity_en   <= RST_PARITY_EN;
      q.linefeed    <= RST_LINEFEED;
      q.alarm_en    <= RST_ALARM_EN;
      q.reply_delay <= RST_REPLY_DELAY;
      q.modbus_req  <= RST_MODBUS;
      q.modbus_act  <= RST_MODBUS;
      q.bitc        <= FALLBACK_BIT_CYCLES;
      q.chen        <= 4'hf;
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o      = q.dat;
  assign wb_ack_o      = q.ack;
  assign bit_cycles    = q.bitc;
  assign fallback      = q.fb;
  assign modbus_active = q.modbus_act;
  assign chan_enable   = q.chen;
  assign prog_reset    = q.prst;
endmodule : fcad_core
`default_nettype wire

// file: core/fcad_pkg.sv
// Package with constants and types shared by the fallback command front end.
`default_nettype none
package fcad_pkg;
  localparam int unsigned CLK_HZ              = 40_000_000;
  localparam int unsigned FALLBACK_BAUD       = 300;
  localparam int unsigned BAUD_DIV_W          = 20;
  // Divider reload value: clock cycles per bit at the 300-baud fallback rate.
  localparam logic [19:0] FALLBACK_BIT_CYCLES = 20'(CLK_HZ / FALLBACK_BAUD);
  // Pin debounce window in microseconds and its cycle count at 40 cycles per microsecond.
  localparam int unsigned DEBOUNCE_US         = 2000;
  localparam int unsigned DEBOUNCE_CYCLES     = (DEBOUNCE_US * 40 + 0) ;
  // Factory setup values.
  localparam logic [7:0]  RST_ADDR            = 8'h31;
  localparam logic [2:0]  RST_BAUD_SEL        = 3'h0;
  localparam logic        RST_PARITY_EN       = 1'b0;
  localparam logic        RST_LINEFEED        = 1'b0;
  localparam logic        RST_ALARM_EN        = 1'b0;
  localparam logic [1:0]  RST_REPLY_DELAY     = 2'h2;
  localparam logic        RST_MODBUS          = 1'b0;
  // Illegal address characters, then the characters of a reply.
  localparam logic [7:0]  CH_NUL              = 8'h00;
  localparam logic [7:0]  CH_CR               = 8'h0d;
  localparam logic [7:0]  CH_DOLLAR           = 8'h24;
  localparam logic [7:0]  CH_HASH             = 8'h23;
  localparam logic [7:0]  CH_LBRACE           = 8'h7b;
  localparam logic [7:0]  CH_RBRACE           = 8'h7d;
  localparam logic [7:0]  CH_STAR             = 8'h2a;
  localparam logic [7:0]  CH_PLUS             = 8'h2b;
  localparam logic [7:0]  CH_MINUS            = 8'h2d;
  localparam logic [7:0]  CH_DOT              = 8'h2e;
  localparam logic [7:0]  CH_ZERO             = 8'h30;
  localparam int unsigned REPLY_LEN           = 10;
  // Register offsets (byte addresses).
  localparam logic [3:0]  OFS_CMD             = 4'h0;
  localparam logic [3:0]  OFS_SETUP           = 4'h4;
  localparam logic [3:0]  OFS_STATUS          = 4'h8;
  localparam logic [3:0]  OFS_DATA            = 4'hc;
  // Command codes written to the command register.
  typedef enum logic [2:0] {
    FCAD_CMD_NONE       = 3'h0,
    FCAD_CMD_READ_DATA  = 3'h1,
    FCAD_CMD_READ_SETUP = 3'h2,
    FCAD_CMD_SETUP_WR   = 3'h3,
    FCAD_CMD_MB_EN      = 3'h4,
    FCAD_CMD_MB_DIS     = 3'h5
  } fcad_cmd_t;
  typedef enum logic [2:0] {
    FCAD_ST_IDLE  = 3'b001,
    FCAD_ST_EXEC  = 3'b010,
    FCAD_ST_REPLY = 3'b100
  } fcad_state_t;
endpackage : fcad_pkg
`default_nettype wire

// file: core/fcad_pin_filter.sv
// Synchroniser and debouncer for the mode-force pin.
`default_nettype none
module fcad_pin_filter
  import fcad_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = DEBOUNCE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic pin_raw,
  output logic      level,
  output logic      rise
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        lvl;
    logic        rise;
    logic [31:0] cnt;
  } fcad_pf_t;
  fcad_pf_t q;
  fcad_pf_t next_q;

  always_comb begin
    next_q      = q;
    next_q.s1   = pin_raw;
    next_q.s2   = q.s1;
    next_q.rise = 1'b0;
    // Only the second stage is read; the first feeds only the second.
    if (q.s2 == q.lvl) begin
      next_q.cnt = '0;
    end else if (q.cnt >= STABLE_CYCLES - 1) begin
      next_q.cnt  = '0;
      next_q.lvl  = q.s2;
      next_q.rise = q.s2;
    end else begin
      next_q.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, rise: 1'b0, cnt: 32'h0};
    end else begin
      q <= next_q;
    end
  end

  assign level = q.lvl;
  assign rise  = q.rise;
endmodule : fcad_pin_filter
`default_nettype wire

// file: core/fcad_skid.sv
// Two-entry buffer with valid and ready on both sides.
`default_nettype none
module fcad_skid
  import fcad_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            cnt;
    logic                  rd;
    logic                  wr;
    logic                  ov;
    logic [WIDTH-1:0]      od;
  } fcad_sk_t;
  fcad_sk_t q;
  fcad_sk_t next_q;
  logic push;
  logic pop;

  always_comb begin
    next_q = q;
    push   = in_valid && (q.cnt != 2'h2);
    pop    = out_ready && (q.cnt != 2'h0);
    if (push) begin
      next_q.mem[q.wr] = in_data;
      next_q.wr        = ~q.wr;
    end
    if (pop) begin
      next_q.rd = ~q.rd;
    end
    next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    // The head word and its valid are registered so the stream leaves from flip-flops.
    next_q.ov  = (next_q.cnt != 2'h0);
    next_q.od  = next_q.mem[next_q.rd];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign in_ready  = (q.cnt != 2'h2);
  assign out_valid = q.ov;
  assign out_data  = q.od;
endmodule : fcad_skid
`default_nettype wire

// file: tb/fcad_host.sv
// Host model that takes reply bytes off the stream, stalling when asked.
`default_nettype none
module fcad_host (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       slow,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q[$];
  logic [1:0] ph;
  // A single listener on the link; the stalls prove the buffer loses no byte.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (tx_valid && tx_ready) rx_q.push_back(tx_byte);
    end
  end
  assign tx_ready = !slow || (ph == 2'h3);
endmodule : fcad_host
`default_nettype wire

// file: tb/fcad_core_props.sv
// Checker of the command front end, bound to its top module.
`default_nettype none
module fcad_core_props
  import fcad_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES
) (
  input wire logic             clock,
  input wire logic             rst_b,
  input wire logic             force_pin_b,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [3:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [3:0][19:0] chan_value,
  input wire logic [3:0]       chan_neg,
  input wire logic [7:0]       tx_byte,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire logic [19:0]      bit_cycles,
  input wire logic             fallback,
  input wire logic             modbus_active,
  input wire logic [3:0]       chan_enable,
  input wire logic             prog_reset
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  AST_ACK_DUE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_FB_BAUD: assert property (fallback |-> bit_cycles == FALLBACK_BIT_CYCLES)
    else $error("fallback bit time wrong");
  AST_FB_CHAN: assert property (fallback |-> chan_enable == 4'hf)
    else $error("channel disabled in fallback");
  AST_FB_ENTRY: assert property ($rose(fallback) |-> !$past(force_pin_b, 3))
    else $error("fallback without settled pin");
  AST_RST_ONE: assert property (prog_reset |=> !prog_reset [*3])
    else $error("program reset repeated");
  AST_RST_EXIT: assert property ($fell(fallback) |-> $past(prog_reset) or ##[0:1] prog_reset)
    else $error("release without program reset");
  AST_MB_AFTER: assert property ($rose(modbus_active) |-> prog_reset || $past(prog_reset))
    else $error("modbus active without reset");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte lost in stall");
endmodule : fcad_core_props
bind fcad_core fcad_core_props #(.DEBOUNCE(DEBOUNCE)) u_props (
  .clock(clock), .rst_b(rst_b), .force_pin_b(force_pin_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_value(chan_value),
  .chan_neg(chan_neg), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .bit_cycles(bit_cycles), .fallback(fallback), .modbus_active(modbus_active),
  .chan_enable(chan_enable), .prog_reset(prog_reset));
`default_nettype wire

// file: tb/fcad_core_tb.sv
// Self-checking bench of the command front end.
`default_nettype none
module fcad_core_tb
  import fcad_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_b, pin, cyc, stb, we, ack, txv, txr, fb, mb, prs, slow;
  logic [3:0] adr, cen, neg, sel;
  logic [31:0] dw, dr, q;
  logic [3:0][19:0] cval;
  logic [7:0] txb;
  logic [19:0] bc;
  int num_errors, checked, pulses, n;
  logic [7:0] bad[6] = '{CH_NUL, CH_CR, CH_DOLLAR, CH_HASH, CH_LBRACE, CH_RBRACE};
  fcad_core #(.DEBOUNCE(4)) DUT (.clock(clock), .rst_b(rst_b), .force_pin_b(pin),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .chan_value(cval), .chan_neg(neg),
    .tx_byte(txb), .tx_valid(txv), .tx_ready(txr), .bit_cycles(bc), .fallback(fb),
    .modbus_active(mb), .chan_enable(cen), .prog_reset(prs));
  fcad_host host (.clock(clock), .rst_b(rst_b), .slow(slow), .tx_byte(txb),
    .tx_valid(txv), .tx_ready(txr));
  always #12.5 clock = ~clock;
  always @(posedge clock) if (prs === 1'b1) pulses++;
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    adr <= a;
    we <= w;
    sel <= 4'hf;
    dw <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    // The acknowledge ends the wait; only the watchdog ends it if none comes.
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic cmd(input logic [31:0] d);
    wb(OFS_CMD, 1'b1, d);
    for (int k = 0; k < 40; k++) begin
      wb(OFS_STATUS, 1'b0, 32'h0);
      if (q[2:0] === 3'h1) break;
    end
    chk(q[2:0], 32'h1);
  endtask : cmd
  function automatic logic [7:0] exp_byte(input logic [19:0] v, input logic ng, input int k);
    int p;
    p = (k < 7) ? 8 - k : 9 - k;
    if (k == 0) return CH_STAR;
    if (k == 1) return ng ? CH_MINUS : CH_PLUS;
    if (k == 7) return CH_DOT;
    return CH_ZERO + 8'((int'(v) / (10 ** p)) % 10);
  endfunction : exp_byte
  task automatic reply(input int ch, input logic [7:0] ad);
    host.rx_q.delete();
    cmd({16'h0, ad, 8'h01});
    for (int k = 0; k < 400 && host.rx_q.size() < REPLY_LEN; k++) @(posedge clock);
    chk(host.rx_q.size(), REPLY_LEN);
    for (int k = 0; k < REPLY_LEN; k++) chk(host.rx_q[k], exp_byte(cval[ch], neg[ch], k));
  endtask : reply
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end
  initial begin
    {clock, rst_b, cyc, stb, we, adr, sel, dw, num_errors, checked, pulses} = '0;
    pin = 1'b1;
    slow = 1'b1;
    neg = 4'b0010;
    cval = {20'd0, 20'd0, 20'd123456, 20'd2500};
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    wb(OFS_SETUP, 1'b0, 32'h0);
    chk(q[17:0], 32'h10031);
    chk(bc, FALLBACK_BIT_CYCLES);
    chk(mb, 1'b0);
    reply(0, 8'h31);
    pin <= 1'b0;
    for (n = 0; n < 40 && fb !== 1'b1; n++) @(posedge clock);
    chk(fb, 1'b1);
    wb(OFS_SETUP, 1'b0, 32'h0);
    chk(q[17:0], 32'h10031);
    chk(cen, 4'hf);
    reply(0, 8'h41);
    slow <= 1'b0;
    reply(1, 8'h32);
    // An illegal address character must draw no reply at all.
    foreach (bad[i]) begin
      host.rx_q.delete();
      cmd({16'h0, bad[i], 8'h01});
      chk(q[8], 1'b1);
      repeat (60) @(posedge clock);
      chk(host.rx_q.size(), 0);
    end
    cmd(32'h0b31_3103);
    chk(bc, FALLBACK_BIT_CYCLES);
    wb(OFS_SETUP, 1'b0, 32'h0);
    chk(q[17:0], 32'h11631);
    cmd(32'h0000_3104);
    chk(mb, 1'b0);
    pulses = 0;
    pin <= 1'b1;
    @(posedge clock);
    pin <= 1'b0;
    @(posedge clock);
    pin <= 1'b1;
    repeat (40) @(posedge clock);
    chk(pulses, 1);
    chk(bc, FALLBACK_BIT_CYCLES >> 3);
    chk(mb, 1'b1);
    // Outside fallback an unassigned address draws no reply.
    host.rx_q.delete();
    cmd({16'h0, 8'h41, 8'h01});
    chk(q[8], 1'b1);
    repeat (60) @(posedge clock);
    chk(host.rx_q.size(), 0);
    cmd(32'h0000_3105);
    chk(mb, 1'b0);
    wb(4'h2, 1'b0, 32'h0);
    chk(q, 32'h0);
    complete_run();
  end
endmodule : fcad_core_tb
`default_nettype wire
